// [hdl/lvd_pkg.sv]
// constants shared by the power-on and low-voltage reset sequencer
package lvd_pkg;
  // clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int POR_FILT_NS = 100;
  localparam int POR_FILT_CYCLES = (POR_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRESCALE_CYCLES = 131072;
  localparam int PRESCALE_W = 18;
  localparam int SETTLE_DIV = 4;
  // control word field positions
  localparam int CTL_DET_EN = 4;
  localparam int CTL_LVL_SEL = 3;
  localparam int CTL_RST_EN = 2;
  localparam int CTL_DROP_EN = 1;
  localparam int CTL_RISE_EN = 0;
  localparam int CTL_W = 5;
  // status word field positions
  localparam int STA_SETTLE = 2;
  localparam int STA_DROP = 1;
  localparam int STA_RISE = 0;
  localparam int STA_W = 3;
  // reset values
  localparam logic [CTL_W-1:0] CTL_RESET = 5'h00;
  localparam logic [7:0] SETTLE_RESET = 8'h00;
  localparam logic [7:0] SETTLE_LAST = 8'hFF;
  // comparator bundle positions
  localparam int CMP_RST_LO = 0;
  localparam int CMP_RST_HI = 1;
  localparam int CMP_DROP = 2;
  localparam int CMP_RISE = 3;
  localparam int CMP_XDROP = 4;
  localparam int CMP_XRISE = 5;
  localparam int CMP_W = 6;
endpackage

// [hdl/lvd_sync.sv]
// two-flop synchroniser for the comparator outputs
`timescale 1ns/1ps
`default_nettype none
module lvd_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // asynchronous levels in, synchronous levels out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  // first stage is read only by the second stage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // lvd_sync
`default_nettype wire

// [hdl/lvd_seq.sv]
// power-on and low-voltage reset sequencer with supply event detection
// Operation
// RQ1: clear pin low holds prescaler and chip in reset; release starts counting.
// RQ2: chip reset released only after prescaler counts 131072 clock cycles.
// RQ3: clear pin filtered so glitches under about 100 ns are ignored.
// RQ4: after power-on reset both detection units start disabled until software enables.
// RQ5: software sets detector enable, waits 150 us, then reset enable.
// RQ6: software clears reset enable before detector enable, never together.
// RQ7: supply below reset level drives low-voltage reset low and holds prescaler.
// RQ8: after recovery prescaler counts 131072 again; control bits survive that reset.
// RQ9: software sets detector enable, waits 150 us, then both interrupt enables.
// RQ10: software clears interrupt enables before detector enable, in separate writes.
// RQ11: drop below level drives interrupt signal low, sets drop flag, irq if enabled.
// RQ12: rise without reset drop sets interrupt signal high; flag and irq if enabled.
// RQ13: software saves data and enters standby after a drop interrupt.
// RQ14: external sensing uses drop and rise sense pins for the same events.
// RQ15: software waits for settle done, clears flags, then sets enables.
// RQ16: detector enable write starts 8-bit settle counter at clk/4; wrap sets flag.
// RQ17: flags clear only by writing 0 after reading them as 1.
// RQ18: standby control 0 puts detection block in standby, 1 cancels it.
// RQ19: comparator outputs pass two flip-flops before any use.
// RQ20: each crossing gives one flag set and one irq, not repeated.
`timescale 1ns/1ps
`default_nettype none
module lvd_seq #(
  parameter int PRESCALE = lvd_pkg::PRESCALE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // external power-on clear pin, low means clear
  input wire logic power_on_clear_pin,
  // analog comparators: 1 = below reset level (low / high setting), below drop, above rise
  input wire logic cmp_reset_lo,
  input wire logic cmp_reset_hi,
  input wire logic cmp_drop_low,
  input wire logic cmp_rise_high,
  // external sense pin comparators, 1 = pin above its threshold
  input wire logic drop_sense_pin,
  input wire logic rise_sense_pin,
  input wire logic ext_sense_select,
  // module standby control, 0 = standby
  input wire logic detector_standby_ctrl,
  // control word write
  input wire logic ctrl_wr,
  input wire logic [lvd_pkg::CTL_W-1:0] ctrl_wdata,
  // status access: read strobe, write strobe with data
  input wire logic status_rd,
  input wire logic status_wr,
  input wire logic [lvd_pkg::STA_W-1:0] status_wdata,
  // reset and interrupt outputs
  output logic chip_reset_n,
  output logic lowvolt_reset_n,
  output logic lowvolt_int_n,
  output logic supply_event_irq,
  // readback
  output logic detector_enable,
  output logic reset_level_select,
  output logic lowvolt_reset_enable,
  output logic drop_irq_enable,
  output logic rise_irq_enable,
  output logic settle_done_flag,
  output logic drop_flag,
  output logic rise_flag,
  output logic [7:0] settle_counter
);
  import lvd_pkg::*;

  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(PRESCALE - 1);
  localparam logic [1:0] FILT_LAST = 2'(POR_FILT_CYCLES - 1);
  localparam logic [1:0] DIV_LAST = 2'(SETTLE_DIV - 1);

  logic por_ok;
  logic [1:0] filt_cnt;
  logic [PRESCALE_W-1:0] presc_cnt;
  logic [CMP_W-1:0] cmp_s;
  logic drop_low_q, rise_high_q;
  logic fell_to_reset;
  logic settle_run;
  logic [1:0] div_cnt;
  logic settle_armed, drop_armed, rise_armed;

  // power-on clear glitch filter: a change must hold for the filter length
  always_ff @(posedge clk) begin
    if (!rstn) begin
      por_ok <= 1'b0;
      filt_cnt <= 2'h0;
    end else if (power_on_clear_pin == por_ok) begin
      filt_cnt <= 2'h0;
    end else if (filt_cnt == FILT_LAST) begin
      por_ok <= power_on_clear_pin; // [RQ3]
      filt_cnt <= 2'h0;
    end else begin
      filt_cnt <= filt_cnt + 2'h1;
    end
  end

  // comparator synchronisation
  lvd_sync #(.WIDTH(CMP_W)) u_sync (
    .clk(clk),
    .rstn(rstn),
    .async_in({rise_sense_pin, drop_sense_pin, cmp_rise_high, cmp_drop_low, cmp_reset_hi, cmp_reset_lo}),
    .sync_out(cmp_s) // [RQ19]
  );

  // detection only acts when enabled and out of module standby
  logic active;
  logic reset_low, drop_low, rise_high;
  logic lv_trip, drop_event, rise_event;
  assign active = detector_enable & detector_standby_ctrl; // [RQ18]
  assign reset_low = reset_level_select ? cmp_s[CMP_RST_HI] : cmp_s[CMP_RST_LO];
  assign drop_low = ext_sense_select ? ~cmp_s[CMP_XDROP] : cmp_s[CMP_DROP]; // [RQ14]
  assign rise_high = ext_sense_select ? cmp_s[CMP_XRISE] : cmp_s[CMP_RISE]; // [RQ14]
  assign lv_trip = active & lowvolt_reset_enable & reset_low;
  // edge, not level, so a held level never repeats the event
  assign drop_event = active & drop_low & ~drop_low_q; // [RQ20]
  assign rise_event = active & rise_high & ~rise_high_q & ~lowvolt_int_n & ~fell_to_reset; // [RQ12]

  // edge history of the synchronised levels
  always_ff @(posedge clk) begin
    if (!rstn) begin
      drop_low_q <= 1'b0;
      rise_high_q <= 1'b0;
    end else begin
      drop_low_q <= drop_low;
      rise_high_q <= rise_high;
    end
  end

  // startup prescaler and chip reset
  always_ff @(posedge clk) begin
    if (!rstn || !por_ok || lv_trip) begin
      presc_cnt <= '0; // [RQ1] [RQ7]
      chip_reset_n <= 1'b0;
    end else if (!chip_reset_n) begin
      presc_cnt <= presc_cnt + PRESCALE_W'(1);
      chip_reset_n <= (presc_cnt == PRESCALE_LAST); // [RQ2] [RQ8]
    end
  end

  // low-voltage reset output
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lowvolt_reset_n <= 1'b1;
    end else begin
      lowvolt_reset_n <= ~lv_trip; // [RQ7]
    end
  end

  // control bits: cleared by power-on, kept through a low-voltage reset
  always_ff @(posedge clk) begin
    if (!rstn || !por_ok) begin
      {detector_enable, reset_level_select, lowvolt_reset_enable, drop_irq_enable, rise_irq_enable}
        <= CTL_RESET; // [RQ4] [RQ8]
    end else if (ctrl_wr) begin
      detector_enable <= ctrl_wdata[CTL_DET_EN];
      reset_level_select <= ctrl_wdata[CTL_LVL_SEL];
      lowvolt_reset_enable <= ctrl_wdata[CTL_RST_EN];
      drop_irq_enable <= ctrl_wdata[CTL_DROP_EN];
      rise_irq_enable <= ctrl_wdata[CTL_RISE_EN];
    end
  end

  // settle counter at a quarter of the clock, one pass per 0 to 1 enable write
  logic settle_tick, settle_wrap;
  assign settle_tick = settle_run & detector_standby_ctrl & (div_cnt == DIV_LAST);
  assign settle_wrap = settle_tick & (settle_counter == SETTLE_LAST);
  always_ff @(posedge clk) begin
    if (!rstn || !por_ok) begin
      settle_run <= 1'b0;
      div_cnt <= 2'h0;
      settle_counter <= SETTLE_RESET;
    end else if (ctrl_wr && ctrl_wdata[CTL_DET_EN] && !detector_enable) begin
      settle_run <= 1'b1; // [RQ16]
      div_cnt <= 2'h0;
      settle_counter <= SETTLE_RESET;
    end else if (!detector_enable) begin
      settle_run <= 1'b0;
    end else if (settle_run && detector_standby_ctrl) begin
      div_cnt <= div_cnt + 2'h1;
      if (settle_tick) begin
        settle_counter <= settle_counter + 8'h01;
      end
      if (settle_wrap) begin
        settle_run <= 1'b0; // [RQ16]
      end
    end
  end

  // read-then-write-zero clearing; a set in the same cycle wins
  logic clr_settle, clr_drop, clr_rise;
  assign clr_settle = status_wr & ~status_wdata[STA_SETTLE] & settle_armed; // [RQ17]
  assign clr_drop = status_wr & ~status_wdata[STA_DROP] & drop_armed; // [RQ17]
  assign clr_rise = status_wr & ~status_wdata[STA_RISE] & rise_armed; // [RQ17]

  // status flags, also cleared by the low-voltage reset itself
  always_ff @(posedge clk) begin
    if (!rstn || !por_ok || lv_trip) begin
      settle_done_flag <= 1'b0;
      drop_flag <= 1'b0;
      rise_flag <= 1'b0;
    end else begin
      if (settle_wrap) begin
        settle_done_flag <= 1'b1; // [RQ16]
      end else if (clr_settle) begin
        settle_done_flag <= 1'b0;
      end
      if (drop_event) begin
        drop_flag <= 1'b1; // [RQ11]
      end else if (clr_drop) begin
        drop_flag <= 1'b0;
      end
      if (rise_event && rise_irq_enable) begin
        rise_flag <= 1'b1; // [RQ12]
      end else if (clr_rise) begin
        rise_flag <= 1'b0;
      end
    end
  end

  // arming: a read that sees 1 allows the next zero write to clear
  always_ff @(posedge clk) begin
    if (!rstn || !por_ok) begin
      {settle_armed, drop_armed, rise_armed} <= 3'h0;
    end else begin
      if (status_wr) begin
        {settle_armed, drop_armed, rise_armed} <= 3'h0;
      end else if (status_rd) begin
        settle_armed <= settle_done_flag;
        drop_armed <= drop_flag;
        rise_armed <= rise_flag;
      end
    end
  end

  // interrupt signal, reset-episode memory and the irq pulse
  always_ff @(posedge clk) begin
    if (!rstn || !por_ok) begin
      lowvolt_int_n <= 1'b1;
      fell_to_reset <= 1'b0;
      supply_event_irq <= 1'b0;
    end else begin
      supply_event_irq <= (drop_event & drop_irq_enable) | (rise_event & rise_irq_enable); // [RQ11] [RQ12]
      if (drop_event) begin
        lowvolt_int_n <= 1'b0; // [RQ11]
        fell_to_reset <= 1'b0;
      end else if (rise_event) begin
        lowvolt_int_n <= 1'b1; // [RQ12]
      end else if (reset_low && !lowvolt_int_n) begin
        fell_to_reset <= 1'b1;
      end
    end
  end

  // checks
  por_hold_a: assert property (@(posedge clk) disable iff (!rstn) !por_ok |=> !chip_reset_n) // [RQ1]
    else $error("chip reset released while clear pin low");
  release_count_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(chip_reset_n) |-> $past(presc_cnt) == PRESCALE_LAST) // [RQ2]
    else $error("chip reset released at wrong prescaler count");
  clear_filter_a: assert property (@(posedge clk) disable iff (!rstn)
    $changed(por_ok) |-> ($past(power_on_clear_pin, 1) == por_ok) && ($past(power_on_clear_pin, 2) == por_ok)) // [RQ3]
    else $error("clear pin filter passed a short pulse");
  por_standby_a: assert property (@(posedge clk) disable iff (!rstn)
    !por_ok |=> !detector_enable && !lowvolt_reset_enable && !drop_irq_enable && !rise_irq_enable) // [RQ4]
    else $error("detection enabled after power-on clear");
  lv_reset_a: assert property (@(posedge clk) disable iff (!rstn)
    lv_trip |=> !lowvolt_reset_n && !chip_reset_n && presc_cnt == '0) // [RQ7]
    else $error("low-voltage reset not applied");
  ctl_keep_a: assert property (@(posedge clk) disable iff (!rstn)
    lv_trip && por_ok && !ctrl_wr |=> $stable(detector_enable) && $stable(lowvolt_reset_enable)) // [RQ8]
    else $error("control bits lost in low-voltage reset");
  drop_event_a: assert property (@(posedge clk) disable iff (!rstn || !por_ok || lv_trip)
    drop_event |=> !lowvolt_int_n && drop_flag && (supply_event_irq == $past(drop_irq_enable))) // [RQ11]
    else $error("drop event not reported");
  rise_event_a: assert property (@(posedge clk) disable iff (!rstn || !por_ok || lv_trip)
    rise_event |=> lowvolt_int_n && (rise_flag == $past(rise_irq_enable)) && (supply_event_irq == $past(rise_irq_enable))) // [RQ12]
    else $error("rise event not reported");
  settle_wrap_a: assert property (@(posedge clk) disable iff (!rstn || !por_ok || lv_trip)
    settle_wrap |=> settle_done_flag && settle_counter == SETTLE_RESET) // [RQ16]
    else $error("settle wrap did not set flag");
  flag_clear_a: assert property (@(posedge clk) disable iff (!rstn || !por_ok || lv_trip)
    $fell(drop_flag) |-> $past(drop_armed) && $past(status_wr) && !$past(status_wdata[STA_DROP])) // [RQ17]
    else $error("drop flag cleared without read then zero write");
  standby_mask_a: assert property (@(posedge clk) disable iff (!rstn)
    !detector_standby_ctrl |=> lowvolt_reset_n && !supply_event_irq) // [RQ18]
    else $error("detection acted in module standby");
  irq_once_a: assert property (@(posedge clk) disable iff (!rstn) supply_event_irq |=> !supply_event_irq) // [RQ20]
    else $error("irq repeated for one crossing");
  release_c: cover property (@(posedge clk) disable iff (!rstn) $rose(chip_reset_n));
  settle_c: cover property (@(posedge clk) disable iff (!rstn) $rose(settle_done_flag));
  drop_rise_c: cover property (@(posedge clk) disable iff (!rstn) $fell(lowvolt_int_n) ##[1:1000] $rose(lowvolt_int_n));
  lv_reset_c: cover property (@(posedge clk) disable iff (!rstn) $fell(lowvolt_reset_n));
endmodule // lvd_seq
`default_nettype wire

// [verif/lvd_supply_model.sv]
// supply comparator model standing in for the analog front end
`timescale 1ns/1ps
`default_nettype none
module lvd_supply_model #(
  parameter int RST_LO = 23,
  parameter int RST_HI = 33,
  parameter int DROP = 37,
  parameter int RISE = 40
) (
  // supply level in tenths of a volt
  input wire logic [7:0] supply,
  // on-chip comparators
  output logic cmp_reset_lo,
  output logic cmp_reset_hi,
  output logic cmp_drop_low,
  output logic cmp_rise_high,
  // external sense dividers, 1 = above threshold
  output logic drop_sense_pin,
  output logic rise_sense_pin
);
  // comparators switch at once, no hysteresis, so the syncs see raw edges
  assign cmp_reset_lo = supply < RST_LO;
  assign cmp_reset_hi = supply < RST_HI;
  assign cmp_drop_low = supply < DROP;
  assign cmp_rise_high = supply > RISE;
  // sense pins track the same supply through their dividers
  assign drop_sense_pin = supply >= DROP;
  assign rise_sense_pin = supply > RISE;
endmodule // lvd_supply_model
`default_nettype wire

// [verif/lvd_seq_test.sv]
// self-checking bench for the reset sequencer with supply events
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("BAD t=%0t got %0h exp %0h", $time, (a), (b)); end end
module lvd_seq_test;
  import lvd_pkg::*;
  localparam int PS = 16;
  logic clk = 0, rstn = 0, pin = 0, ext = 0, stby = 1, cwr = 0, srd = 0, swr = 0;
  logic [4:0] cwd = 5'h00;
  logic [2:0] swd = 3'h7;
  logic [7:0] vdd = 8'h32;
  logic [7:0] scnt;
  logic [1:0] e;
  logic c_lo, c_hi, c_dr, c_ri, x_dr, x_ri, chip_n, lvr_n, lvi_n, irq;
  logic de, sel, re, dde, ude, sdf, df, uf;
  int err_count = 0, samples_checked = 0, irqs = 0, h, b;
  integer seed = 32'ha1bfaed4;

  lvd_supply_model model (.supply(vdd), .cmp_reset_lo(c_lo), .cmp_reset_hi(c_hi), .cmp_drop_low(c_dr),
    .cmp_rise_high(c_ri), .drop_sense_pin(x_dr), .rise_sense_pin(x_ri));
  lvd_seq #(.PRESCALE(PS)) dut (.clk(clk), .rstn(rstn), .power_on_clear_pin(pin), .cmp_reset_lo(c_lo),
    .cmp_reset_hi(c_hi), .cmp_drop_low(c_dr), .cmp_rise_high(c_ri), .drop_sense_pin(x_dr),
    .rise_sense_pin(x_ri), .ext_sense_select(ext), .detector_standby_ctrl(stby), .ctrl_wr(cwr),
    .ctrl_wdata(cwd), .status_rd(srd), .status_wr(swr), .status_wdata(swd), .chip_reset_n(chip_n),
    .lowvolt_reset_n(lvr_n), .lowvolt_int_n(lvi_n), .supply_event_irq(irq), .detector_enable(de),
    .reset_level_select(sel), .lowvolt_reset_enable(re), .drop_irq_enable(dde), .rise_irq_enable(ude),
    .settle_done_flag(sdf), .drop_flag(df), .rise_flag(uf), .settle_counter(scnt));

  // 20 MHz clock
  always #25 clk = ~clk;
  // irq pulses counted so a repeated pulse shows up
  always @(posedge clk) if (irq === 1'b1) irqs++;

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one-cycle control write, launched at a falling edge
  task automatic wctl(input logic [4:0] v);
    cwd = v;
    cwr = 1;
    cyc(1);
    cwr = 0;
    cyc(1);
  endtask
  // read to arm, then write the given bits back
  task automatic clrf(input logic [2:0] v);
    srd = 1;
    cyc(1);
    srd = 0;
    swd = v;
    swr = 1;
    cyc(1);
    swr = 0;
    cyc(1);
  endtask
  // bounded wait for chip reset release
  task automatic wait_chip(input int lim);
    int n;
    n = 0;
    while (chip_n !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
    end
  endtask
  function automatic int exp_irqs(input logic [1:0] en);
    return int'(en[1]) + int'(en[0]);
  endfunction
  task automatic wrap_up;
    $display("checked %0d bad %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // watchdog: whole run needs about 5400 cycles
  initial begin
    cyc(12000);
    err_count++;
    wrap_up();
  end

  // main sequence
  initial begin
    cyc(4);
    rstn = 1;
    cyc(6);
    `CHK(chip_n, 1'b0)
    `CHK({de, sel, re, dde, ude}, 5'h00)
    pin = 1;
    cyc(1);
    pin = 0;
    cyc(PS + 6);
    `CHK(chip_n, 1'b0)
    pin = 1;
    cyc(PS - 1);
    `CHK(chip_n, 1'b0)
    wait_chip(8);
    `CHK(chip_n, 1'b1)
    $display("power-on test done");
    wctl(5'h10);
    cyc(1000);
    `CHK(sdf, 1'b0)
    cyc(30);
    `CHK(sdf, 1'b1)
    `CHK(scnt, 8'h00)
    cyc(2000); // software still waits out the full settle time
    swd = 3'h0;
    swr = 1;
    cyc(1);
    swr = 0;
    cyc(1);
    `CHK(sdf, 1'b1)
    clrf(3'h0);
    `CHK({sdf, df, uf}, 3'h0)
    $display("settle test done");
    // random enables, hold times and sense source per swing
    for (int i = 0; i < 8; i++) begin
      e = 2'($random(seed));
      ext = 1'($random(seed));
      h = 4 + ($random(seed) & 7);
      wctl({3'b100, e});
      // irq counter has one writer; the bench only takes a base value
      b = irqs;
      vdd = 8'h23;
      cyc(h); // supply held above the reset level while software reacts
      `CHK({lvi_n, df}, 2'b01)
      `CHK(irqs - b, int'(e[1]))
      vdd = 8'h2A;
      cyc(h);
      `CHK({lvi_n, uf}, {1'b1, e[0]})
      `CHK(irqs - b, exp_irqs(e))
      clrf(3'h0);
      wctl(5'h10);
    end
    $display("event test done");
    stby = 0;
    wctl(5'h13);
    b = irqs;
    vdd = 8'h23;
    cyc(8);
    `CHK({irqs - b, df}, {32'd0, 1'b0})
    vdd = 8'h32;
    cyc(8);
    stby = 1;
    cyc(8);
    `CHK(irqs - b, 0)
    $display("standby test done");
    // supply parks between the two reset levels
    for (int s = 0; s < 2; s++) begin
      // detector first, settle time, flags cleared, then reset enable
      wctl(5'h10);
      cyc(1040);
      `CHK(sdf, 1'(s)) // only a 0 to 1 enable write restarts the count
      clrf(3'h0);
      wctl({1'b1, 1'(s), 3'b100});
      vdd = 8'h1E;
      cyc(6);
      `CHK({lvr_n, chip_n}, {2{1'(s == 0)}})
      `CHK({de, sel, re}, {1'b1, 1'(s), 1'b1})
      vdd = 8'h32;
      if (s == 1) begin
        cyc(PS);
        `CHK(chip_n, 1'b0)
      end
      wait_chip(12);
      `CHK(chip_n, 1'b1)
      clrf(3'h0);
      wctl(5'h10);
      wctl(5'h00);
    end
    $display("low-voltage reset test done");
    wrap_up();
  end
endmodule // lvd_seq_test
`default_nettype wire
